// [rtl/arcf_pkg.sv]
package arcf_pkg;

	// Register word indices; byte address is four times the index
	localparam logic [5:0] ARCF_IDX_RATE   = 6'h04;
	localparam logic [5:0] ARCF_IDX_REFCTL = 6'h05;
	localparam logic [5:0] ARCF_IDX_STATUS = 6'h08;
	localparam logic [5:0] ARCF_IDX_MASK   = 6'h09;
	localparam logic [5:0] ARCF_IDX_CMD    = 6'h0A;

	// Rate and clock register fields
	localparam int unsigned ARCF_RATE_CLK_BIT  = 6;
	localparam int unsigned ARCF_RATE_FILT_BIT = 4;
	localparam int unsigned ARCF_RATE_DR_LSB   = 0;
	localparam logic [7:0]  ARCF_RATE_RST      = 8'h14;
	localparam logic [7:0]  ARCF_RATE_MASK     = 8'h5F;

	// Reference control register fields
	localparam int unsigned ARCF_REF_PBUF_BIT = 5;
	localparam int unsigned ARCF_REF_NBUF_BIT = 4;
	localparam int unsigned ARCF_REF_SEL_LSB  = 2;
	localparam int unsigned ARCF_REF_CON_LSB  = 0;
	localparam logic [7:0]  ARCF_REFCTL_RST   = 8'h10;
	localparam logic [7:0]  ARCF_REFCTL_MASK  = 8'h3F;

	// Source select and power encodings
	localparam logic [1:0] ARCF_SEL_EXT0 = 2'h0;
	localparam logic [1:0] ARCF_SEL_EXT1 = 2'h1;
	localparam logic [1:0] ARCF_SEL_INT  = 2'h2;
	localparam logic [1:0] ARCF_CON_PDOFF = 2'h1;
	localparam logic [1:0] ARCF_CON_ON    = 2'h2;

	// Status, mask and command bits
	localparam int unsigned ARCF_ST_CONV = 0;
	localparam int unsigned ARCF_ST_REFL0 = 1;
	localparam int unsigned ARCF_ST_REFL1 = 2;
	localparam int unsigned ARCF_ST_W     = 3;
	localparam int unsigned ARCF_CMD_RESET_BIT = 0;

	// Modulator clock divide and ratio width
	localparam int unsigned ARCF_MOD_DIV = 16;
	localparam int unsigned ARCF_DIV_W   = 4;
	localparam int unsigned ARCF_OSR_W   = 17;

	typedef enum logic [3:0] {
		ARCF_SRC_EXT0 = 4'h1,
		ARCF_SRC_EXT1 = 4'h2,
		ARCF_SRC_INT  = 4'h4,
		ARCF_SRC_NONE = 4'h8
	} arcf_ref_src_e;

	typedef struct packed {
		arcf_ref_src_e src;
		logic          int_ref_on;
		logic          pos_buf_en;
		logic          neg_buf_en;
	} arcf_ref_ctrl_s;

	typedef struct packed {
		logic                  ext_clk_sel;
		logic                  sinc_sel;
		logic [3:0]            output_rate_code;
		logic [ARCF_OSR_W-1:0] osr;
	} arcf_conv_cfg_s;

	// Modulator clocks per result; reserved codes fall back to the fastest
	function automatic logic [ARCF_OSR_W-1:0] arcf_osr(input logic [3:0] code);
		case (code)
			4'h0: arcf_osr = 17'h19000;
			4'h1: arcf_osr = 17'h0C800;
			4'h2: arcf_osr = 17'h06400;
			4'h3: arcf_osr = 17'h03C00;
			4'h4: arcf_osr = 17'h03200;
			4'h5: arcf_osr = 17'h01400;
			4'h6: arcf_osr = 17'h010A8;
			4'h7: arcf_osr = 17'h00A00;
			4'h8: arcf_osr = 17'h00500;
			4'h9: arcf_osr = 17'h00280;
			4'hA: arcf_osr = 17'h00140;
			4'hB: arcf_osr = 17'h00100;
			4'hC: arcf_osr = 17'h00080;
			default: arcf_osr = 17'h00040;
		endcase
	endfunction

endpackage

// [rtl/arcf_top.sv]
// What this block does
// - Two-bit field picks internal or external reference
// - Reset selects external reference pair zero
// - Select value 10 routes internal reference
// - Power 10 always on, 01 off in power-down
// - Internal reference powered down after reset
// - Buffer bits active low: one disables buffer
// - Reference low flags monitored every conversion
// - Clock bit selects internal or external clock
// - Any reset returns to internal oscillator
// - Modulator clock is system clock over 16
// - Filter bit selects sinc or low-latency filter
// - Ratio per rate identical for both filters
// - Four-bit code sets oversampling ratio
// - Filter bit zero means low-latency filter
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module arcf_top (
	// Clock and reset
	input  wire logic                     core_clk_in,
	input  wire logic                     nrst_in,
	// Wishbone slave
	input  wire logic                     wb_cyc_in,
	input  wire logic                     wb_stb_in,
	input  wire logic                     wb_we_in,
	input  wire logic [7:0]               wb_adr_in,
	input  wire logic [3:0]               wb_sel_in,
	input  wire logic [31:0]              wb_dat_in,
	output logic      [31:0]              wb_dat_out,
	output logic                          wb_ack_out,
	// Clock and monitor pins
	input  wire logic                     int_osc_clk_in,
	input  wire logic                     ext_clk_in,
	input  wire logic                     ref_low_pair0_in,
	input  wire logic                     ref_low_pair1_in,
	input  wire logic                     power_down_in,
	// Reference and converter control
	output arcf_pkg::arcf_ref_ctrl_s      ref_ctrl_out,
	output arcf_pkg::arcf_conv_cfg_s      conv_cfg_out,
	output logic                          sys_clk_tick_out,
	output logic                          mod_clk_tick_out,
	output logic                          conv_done_out,
	output logic                          irq_out
);
	import arcf_pkg::*;

	function automatic logic reg_hit(input logic [7:0] adr, input logic [5:0] idx);
		reg_hit = (adr[7:2] == idx);
	endfunction

	// Pin synchronisers: osc, ext clock, low flag 0, low flag 1
	logic [3:0]               sync1_r;
	logic [3:0]               sync2_r;
	logic [1:0]               clk_prev_r;
	logic [3:0]               pin_raw;

	// Registers
	logic [7:0]               rate_and_clock_config_r;
	logic [7:0]               reference_control_r;
	logic [ARCF_ST_W-1:0]     status_r;
	logic [ARCF_ST_W-1:0]     status_nxt;
	logic [ARCF_ST_W-1:0]     mask_r;
	logic                     ack_r;
	logic [31:0]              rdata_r;
	logic                     soft_rst_r;

	// Divider and conversion state
	logic [ARCF_DIV_W-1:0]    div_r;
	logic [ARCF_OSR_W-1:0]    conv_cnt_r;
	logic                     sys_tick_r;
	logic                     mod_tick_r;
	logic                     done_r;

	// Decoded wires
	wire                      hit_rate;
	wire                      hit_ref;
	wire                      hit_status;
	wire                      hit_mask;
	wire                      hit_cmd;
	wire                      bus_req;
	wire                      wr_stb;
	wire                      wr_rate;
	wire                      wr_ref;
	wire                      wr_status;
	wire                      wr_mask;
	wire                      wr_cmd;
	wire [31:0]               rdata_mux;
	wire                      ext_clk_sel;
	wire                      sinc_sel;
	wire [3:0]                output_rate_code;
	wire [1:0]                ref_source_select;
	wire [1:0]                internal_ref_power_ctrl;
	wire                      pos_ref_buffer_disable;
	wire                      neg_ref_buffer_disable;
	wire [ARCF_OSR_W-1:0]     osr;
	wire                      osc_rise;
	wire                      ext_rise;
	wire                      sys_tick;
	wire                      mod_tick;
	wire                      conv_last;
	wire                      ref_low_flag_pair0;
	wire                      ref_low_flag_pair1;
	wire [ARCF_ST_W-1:0]      events;
	arcf_ref_src_e            ref_src;
	wire                      int_ref_on;

	assign pin_raw = {ref_low_pair1_in, ref_low_pair0_in, ext_clk_in, int_osc_clk_in};

	// Edge detect reads stage two only; stage one may be metastable
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sync1_r    <= 4'h0;
			sync2_r    <= 4'h0;
			clk_prev_r <= 2'h0;
		end else begin
			sync1_r    <= pin_raw;
			sync2_r    <= sync1_r;
			clk_prev_r <= sync2_r[1:0];
		end
	end

	// Bus decode
	assign hit_rate   = reg_hit(wb_adr_in, ARCF_IDX_RATE);
	assign hit_ref    = reg_hit(wb_adr_in, ARCF_IDX_REFCTL);
	assign hit_status = reg_hit(wb_adr_in, ARCF_IDX_STATUS);
	assign hit_mask   = reg_hit(wb_adr_in, ARCF_IDX_MASK);
	assign hit_cmd    = reg_hit(wb_adr_in, ARCF_IDX_CMD);
	assign bus_req    = wb_cyc_in & wb_stb_in;
	// Writes land at the ack edge, so a cycle dropped early changes nothing
	assign wr_stb     = bus_req & wb_we_in & ack_r & wb_sel_in[0];
	assign wr_rate    = wr_stb & hit_rate;
	assign wr_ref     = wr_stb & hit_ref;
	assign wr_status  = wr_stb & hit_status;
	assign wr_mask    = wr_stb & hit_mask;
	assign wr_cmd     = wr_stb & hit_cmd;

	// Unmapped addresses still ack and read as zero
	assign rdata_mux =
		hit_rate   ? {24'h000000, rate_and_clock_config_r} :
		hit_ref    ? {24'h000000, reference_control_r} :
		hit_status ? {29'h0000000, status_r} :
		hit_mask   ? {29'h0000000, mask_r} :
		32'h00000000;

	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ack_r   <= 1'b0;
			rdata_r <= 32'h00000000;
		end else begin
			ack_r   <= bus_req & ~ack_r;
			rdata_r <= rdata_mux;
		end
	end

	assign wb_ack_out = ack_r;
	assign wb_dat_out = rdata_r;

	// Soft reset restores configuration one cycle after the command write
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			soft_rst_r <= 1'b0;
		end else begin
			soft_rst_r <= wr_cmd & wb_dat_in[ARCF_CMD_RESET_BIT];
		end
	end

	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rate_and_clock_config_r <= ARCF_RATE_RST;
			reference_control_r     <= ARCF_REFCTL_RST;
		end else if (soft_rst_r) begin
			rate_and_clock_config_r <= ARCF_RATE_RST;
			reference_control_r     <= ARCF_REFCTL_RST;
		end else begin
			if (wr_rate) begin
				rate_and_clock_config_r <= wb_dat_in[7:0] & ARCF_RATE_MASK;
			end
			if (wr_ref) begin
				reference_control_r <= wb_dat_in[7:0] & ARCF_REFCTL_MASK;
			end
		end
	end

	// Field extraction
	assign ext_clk_sel             = rate_and_clock_config_r[ARCF_RATE_CLK_BIT];
	assign sinc_sel                = rate_and_clock_config_r[ARCF_RATE_FILT_BIT];
	assign output_rate_code        = rate_and_clock_config_r[ARCF_RATE_DR_LSB +: 4];
	assign ref_source_select       = reference_control_r[ARCF_REF_SEL_LSB +: 2];
	assign internal_ref_power_ctrl = reference_control_r[ARCF_REF_CON_LSB +: 2];
	assign pos_ref_buffer_disable  = reference_control_r[ARCF_REF_PBUF_BIT];
	assign neg_ref_buffer_disable  = reference_control_r[ARCF_REF_NBUF_BIT];
	assign osr                     = arcf_osr(output_rate_code);

	// Reference multiplexer; reserved code disconnects all sources
	always_comb begin
		case (ref_source_select)
			ARCF_SEL_EXT0: ref_src = ARCF_SRC_EXT0;
			ARCF_SEL_EXT1: ref_src = ARCF_SRC_EXT1;
			ARCF_SEL_INT:  ref_src = ARCF_SRC_INT;
			default:       ref_src = ARCF_SRC_NONE;
		endcase
	end

	assign int_ref_on = (internal_ref_power_ctrl == ARCF_CON_ON) |
		((internal_ref_power_ctrl == ARCF_CON_PDOFF) & ~power_down_in);

	assign ref_ctrl_out.src        = ref_src;
	assign ref_ctrl_out.int_ref_on = int_ref_on;
	assign ref_ctrl_out.pos_buf_en = ~pos_ref_buffer_disable;
	assign ref_ctrl_out.neg_buf_en = ~neg_ref_buffer_disable;

	assign conv_cfg_out.ext_clk_sel      = ext_clk_sel;
	assign conv_cfg_out.sinc_sel         = sinc_sel;
	assign conv_cfg_out.output_rate_code = output_rate_code;
	assign conv_cfg_out.osr              = osr;

	// System clock ticks from the selected source
	assign osc_rise = sync2_r[0] & ~clk_prev_r[0];
	assign ext_rise = sync2_r[1] & ~clk_prev_r[1];
	assign sys_tick = ext_clk_sel ? ext_rise : osc_rise;

	// Modulator tick every sixteenth system tick
	assign mod_tick  = sys_tick & (div_r == 4'(ARCF_MOD_DIV - 1));
	assign conv_last = mod_tick & (conv_cnt_r >= osr - 17'h00001);

	// Rate change restarts the count so a result never spans two ratios
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			div_r      <= 4'h0;
			conv_cnt_r <= 17'h00000;
		end else if (soft_rst_r | wr_rate) begin
			div_r      <= 4'h0;
			conv_cnt_r <= 17'h00000;
		end else begin
			if (sys_tick) begin
				div_r <= div_r + 4'h1;
			end
			if (conv_last) begin
				conv_cnt_r <= 17'h00000;
			end else if (mod_tick) begin
				conv_cnt_r <= conv_cnt_r + 17'h00001;
			end
		end
	end

	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sys_tick_r <= 1'b0;
			mod_tick_r <= 1'b0;
			done_r     <= 1'b0;
		end else begin
			sys_tick_r <= sys_tick;
			mod_tick_r <= mod_tick;
			done_r     <= conv_last;
		end
	end

	assign sys_clk_tick_out = sys_tick_r;
	assign mod_clk_tick_out = mod_tick_r;
	assign conv_done_out    = done_r;

	// Reference low seen on any modulator tick of the running conversion
	assign ref_low_flag_pair0 = mod_tick & sync2_r[2];
	assign ref_low_flag_pair1 = mod_tick & sync2_r[3];

	assign events = {ref_low_flag_pair1, ref_low_flag_pair0, conv_last};

	// Write one clears; a same-cycle event wins over the clear
	always_comb begin
		status_nxt = status_r;
		if (wr_status) begin
			status_nxt = status_r & ~wb_dat_in[ARCF_ST_W-1:0];
		end
		status_nxt = status_nxt | events;
	end

	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			status_r <= 3'h0;
			mask_r   <= 3'h0;
		end else begin
			status_r <= status_nxt;
			if (wr_mask) begin
				mask_r <= wb_dat_in[ARCF_ST_W-1:0];
			end
		end
	end

	// Mask bit one enables the source
	// Level output; software drops it by clearing status
	assign irq_out = |(status_r & mask_r);

endmodule

`default_nettype wire

// [verif/arcf_props.sv]
`timescale 1ns/1ps
`default_nettype none

module arcf_props (
	// Clock, reset and bus
	input  wire logic                     core_clk_in,
	input  wire logic                     nrst_in,
	input  wire logic                     wb_cyc_in,
	input  wire logic                     wb_stb_in,
	input  wire logic                     wb_we_in,
	input  wire logic [7:0]               wb_adr_in,
	input  wire logic [3:0]               wb_sel_in,
	input  wire logic [31:0]              wb_dat_in,
	input  wire logic                     wb_ack_out,
	// Watched outputs
	input  wire arcf_pkg::arcf_ref_ctrl_s ref_ctrl_out,
	input  wire arcf_pkg::arcf_conv_cfg_s conv_cfg_out,
	input  wire logic                     conv_done_out
);
	import arcf_pkg::*;

	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!nrst_in);

	// Write lands at the edge where ack is high
	sequence wr_take;
		wb_cyc_in && wb_stb_in && wb_we_in && wb_ack_out && wb_sel_in[0];
	endsequence
	sequence ref_wr;
		wr_take ##0 (wb_adr_in[7:2] == ARCF_IDX_REFCTL);
	endsequence
	sequence rate_wr;
		wr_take ##0 (wb_adr_in[7:2] == ARCF_IDX_RATE);
	endsequence

	ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("ack longer than one cycle");
	ack_wait_a: assert property ($rose(wb_cyc_in && wb_stb_in) |=> wb_ack_out)
		else $error("ack not one cycle after request");
	rst_val_a: assert property ($rose(nrst_in) |-> ref_ctrl_out.src == ARCF_SRC_EXT0
		&& !ref_ctrl_out.int_ref_on && !conv_cfg_out.ext_clk_sel)
		else $error("wrong state after reset");
	ref_int_a: assert property (ref_wr |=>
		(ref_ctrl_out.src == ARCF_SRC_INT) == ($past(wb_dat_in[3:2]) == 2'h2))
		else $error("internal reference select wrong");
	buf_pol_a: assert property (ref_wr |=>
		ref_ctrl_out.pos_buf_en == !$past(wb_dat_in[5])
		&& ref_ctrl_out.neg_buf_en == !$past(wb_dat_in[4]))
		else $error("buffer enable polarity wrong");
	clk_sel_a: assert property (rate_wr |=>
		conv_cfg_out.ext_clk_sel == $past(wb_dat_in[6]))
		else $error("clock select not from bit 6");
	filt_sel_a: assert property (rate_wr |=>
		conv_cfg_out.sinc_sel == $past(wb_dat_in[4]))
		else $error("filter select not from bit 4");
	osr_max_a: assert property (conv_cfg_out.output_rate_code == 4'h0
		|-> conv_cfg_out.osr == 17'h19000)
		else $error("slowest ratio wrong");
	osr_min_a: assert property (conv_cfg_out.output_rate_code == 4'hD
		|-> conv_cfg_out.osr == 17'h00040)
		else $error("fastest ratio wrong");
	done_pulse_a: assert property (conv_done_out |=> !conv_done_out)
		else $error("done longer than one cycle");
endmodule

bind arcf_top arcf_props u_props (
	.core_clk_in  (core_clk_in),
	.nrst_in      (nrst_in),
	.wb_cyc_in    (wb_cyc_in),
	.wb_stb_in    (wb_stb_in),
	.wb_we_in     (wb_we_in),
	.wb_adr_in    (wb_adr_in),
	.wb_sel_in    (wb_sel_in),
	.wb_dat_in    (wb_dat_in),
	.wb_ack_out   (wb_ack_out),
	.ref_ctrl_out (ref_ctrl_out),
	.conv_cfg_out (conv_cfg_out),
	.conv_done_out(conv_done_out)
);

`default_nettype wire

// [verif/arcf_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module arcf_top_tb;
	import arcf_pkg::*;

	logic           clk = 0, nrst = 0, cyc = 0, stb = 0, we = 0;
	logic           osc = 0, ext = 0, rl0 = 0, rl1 = 0, pd = 0;
	logic [3:0]     sel = 4'hF;
	logic [7:0]     adr = 8'h00;
	logic [31:0]    wdat = 32'h0, rd, d;
	logic [2:0]     od = 3'h0, ed = 3'h0;
	logic           ack, stick, mtick, done, irq;
	arcf_ref_ctrl_s rc;
	arcf_conv_cfg_s cc;
	int             n_fail = 0, n_compared = 0, cyc_n = 0, n;
	localparam int  OSR[14] = '{102400, 51200, 25600, 15360, 12800, 5120, 4264,
		2560, 1280, 640, 320, 256, 128, 64};

	arcf_top u_dut (
		.core_clk_in(clk), .nrst_in(nrst), .wb_cyc_in(cyc), .wb_stb_in(stb),
		.wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
		.wb_dat_out(rd), .wb_ack_out(ack), .int_osc_clk_in(osc), .ext_clk_in(ext),
		.ref_low_pair0_in(rl0), .ref_low_pair1_in(rl1), .power_down_in(pd),
		.ref_ctrl_out(rc), .conv_cfg_out(cc), .sys_clk_tick_out(stick),
		.mod_clk_tick_out(mtick), .conv_done_out(done), .irq_out(irq));

	always #12.5 clk = ~clk;

	// Slow clocks keep the two-stage sync from missing edges
	always @(posedge clk) begin
		od <= (od == 3'h3) ? 3'h0 : od + 3'h1;
		ed <= (ed == 3'h4) ? 3'h0 : ed + 3'h1;
		if (od == 3'h3) osc <= ~osc;
		if (ed == 3'h4) ext <= ~ext;
		cyc_n <= cyc_n + 1;
		if (cyc_n == 60000) begin
			n_fail = n_fail + 1;
			results();
		end
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			n_fail++;
			$display("BAD %0t got %h exp %h", $time, s, e);
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= v;
		@(posedge clk);
		while (ack !== 1'b1) @(posedge clk);
		d = rd;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask

	task automatic span(input bit w, output int k);
		@(posedge clk iff (w ? done : stick) === 1'b1);
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while ((w ? done : stick) !== 1'b1);
	endtask

	task automatic t_reset();
		bus(1'b0, 8'h10, 32'h0);
		chk(d, 32'h14);
		bus(1'b0, 8'h14, 32'h0);
		chk(d, 32'h10);
		chk(32'({rc.src, rc.int_ref_on, cc.ext_clk_sel}), 32'({ARCF_SRC_EXT0, 2'b0}));
		bus(1'b0, 8'h3C, 32'h0);
		chk(d, 32'h0);
		sel <= 4'hE;
		bus(1'b1, 8'h14, 32'h3F);
		sel <= 4'hF;
		bus(1'b0, 8'h14, 32'h0);
		chk(d, 32'h10);
		$display("t_reset done");
	endtask

	task automatic t_ref();
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, 8'h14, 32'((i << 2) | (i == 2 ? 48 : 0)));
			chk(32'(rc.src), 32'(1 << i));
			bus(1'b1, 8'h14, 32'(i << 4));
			chk(32'({rc.pos_buf_en, rc.neg_buf_en}), 32'(~i & 3));
		end
		for (int i = 0; i < 8; i++) begin
			pd <= i[2];
			bus(1'b1, 8'h14, 32'(i & 3));
			chk(32'(rc.int_ref_on), 32'((i & 3) == 2 || ((i & 3) == 1 && !i[2])));
		end
		pd <= 1'b0;
		$display("t_ref done");
	endtask

	task automatic t_rate();
		for (int c = 0; c < 32; c++) begin
			bus(1'b1, 8'h10, 32'(c));
			chk(32'(cc.osr), 32'((c & 15) < 14 ? OSR[c & 15] : 64));
			chk(32'(cc.output_rate_code), 32'(c & 15));
			chk(32'(cc.sinc_sel), 32'(c >> 4));
		end
		$display("t_rate done");
	endtask

	task automatic t_clk();
		bus(1'b1, 8'h10, 32'h5D);
		span(1'b0, n);
		span(1'b0, n);
		chk(32'(n), 32'd10);
		bus(1'b1, 8'h10, 32'h1D);
		span(1'b0, n);
		span(1'b0, n);
		chk(32'(n), 32'd8);
		@(posedge clk iff mtick === 1'b1);
		n = 0;
		do begin
			@(posedge clk);
			n += int'(stick === 1'b1);
		end while (mtick !== 1'b1);
		chk(32'(n), 32'd16);
		$display("t_clk done");
	endtask

	task automatic t_conv();
		bus(1'b1, 8'h14, 32'h10);
		bus(1'b1, 8'h24, 32'h1);
		bus(1'b1, 8'h20, 32'h7);
		span(1'b1, n);
		chk(32'(n), 32'd8192);
		chk(32'(irq), 32'h1);
		bus(1'b1, 8'h20, 32'h1);
		chk(32'(irq), 32'h0);
		for (int p = 1; p < 3; p++) begin
			{rl1, rl0} <= 2'(p);
			repeat (2) @(posedge clk iff mtick === 1'b1);
			{rl1, rl0} <= 2'b00;
			bus(1'b0, 8'h20, 32'h0);
			chk(32'(d[2:1]), 32'(p));
			chk(32'(irq), 32'h0);
			bus(1'b1, 8'h20, 32'h6);
			bus(1'b0, 8'h20, 32'h0);
			chk(32'(d[2:1]), 32'h0);
		end
		$display("t_conv done");
	endtask

	task automatic t_soft();
		bus(1'b1, 8'h10, 32'h5D);
		bus(1'b1, 8'h28, 32'h1);
		bus(1'b0, 8'h10, 32'h0);
		chk(d, 32'h14);
		bus(1'b1, 8'h10, 32'h5D);
		bus(1'b1, 8'h14, 32'h3A);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		chk(32'({rc.src, cc.ext_clk_sel}), 32'({ARCF_SRC_EXT0, 1'b0}));
		$display("t_soft done");
	endtask

	task automatic results();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_ref();
		t_rate();
		t_clk();
		t_conv();
		t_soft();
		results();
	end
endmodule

`default_nettype wire
